// ===== vme_decode_pkg.sv
package vme_decode_pkg;

   // ***************************************
   // Timing
   // ***************************************
   localparam int CLK_PERIOD_NS = 10;
   localparam int ACCESS_NS     = 250;
   localparam int ACCESS_CYC    = (ACCESS_NS + CLK_PERIOD_NS - 1)
                                  / CLK_PERIOD_NS;

   // ***************************************
   // Address modifiers and decode
   // ***************************************
   localparam logic [5:0] AM_SIO_USER = 6'h29;
   localparam logic [5:0] AM_SIO_SUP  = 6'h2d;
   localparam logic [2:0] AUX_MODE_RS = 3'h3;

   // ***************************************
   // Configuration register fields
   // ***************************************
   localparam int         CONFIG_REGISTER_ONE_PRI_LSB = 5;
   localparam int         CONFIG_REGISTER_ONE_BR_LSB  = 3;
   localparam int         CONFIG_REGISTER_ONE_CC_BIT  = 2;
   localparam int         CONFIG_REGISTER_ONE_ROR_BIT = 1;
   localparam int         CONFIG_REGISTER_ONE_DIR_BIT = 0;
   localparam logic [7:0] CONFIG_REGISTER_ONE_RST     = 8'h02;
   localparam int         CONFIG_REGISTER_TWO_LMR_BIT = 0;
   localparam int         CONFIG_REGISTER_TWO_SC_BIT  = 1;
   localparam int         CONFIG_REGISTER_TWO_SUP_BIT = 2;
   localparam int         CONFIG_REGISTER_TWO_SFL_BIT = 3;
   localparam logic [7:0] ALL_ONES     = 8'hff;

   // ***************************************
   // Types
   // ***************************************
   typedef enum logic [1:0] {
      PH_IDLE    = 2'b00,
      PH_ACCESS  = 2'b01,
      PH_ACK     = 2'b10,
      PH_RECOVER = 2'b11
   } phase_t;

   typedef struct packed {
      logic        asN;
      logic        ds0N;
      logic        ds1N;
      logic        iackN;
      logic        writeN;
      logic        berrN;
      logic        sysresetN;
      logic        sysclk;
      logic        dmaDtackN;
      logic        ownN;
      logic        carryByteForce;
      logic        supJumper;
      logic [5:0]  am;
      logic [15:1] addr;
      logic [7:0]  data;
      logic [6:0]  baseJumper;
   } vme_in_t;

endpackage : vme_decode_pkg

// ===== vme_master_model.sv
`timescale 1ns/10ps
// ***************************************
// Short I/O master with DMA controller stand-in
// ***************************************
module vme_master_model #(
   parameter int WAIT_LIMIT = 80,
   parameter int RECOVER    = 40
) (
   input  wire logic                    ref_clk,
   input  wire logic                    localDtackOe,
   input  wire logic                    dmaCtrlSelectN,
   input  wire logic                    dataLoOe,
   input  wire logic                    dataHiOe,
   input  wire logic [7:0]              dataLo,
   input  wire logic [7:0]              dataHi,
   output vme_decode_pkg::vme_in_t      busOut
);
   int dmaCnt;

   initial begin
      busOut = '1;
      dmaCnt = 0;
   end

   // ***************************************
   // Controller answers every own location
   // ***************************************
   always @(posedge ref_clk) begin
      if (!dmaCtrlSelectN && !(busOut.ds0N && busOut.ds1N))
         dmaCnt <= dmaCnt + 1;
      else
         dmaCnt <= 0;
      busOut.dmaDtackN <= !(dmaCnt >= 3);
   end

   // ***************************************
   // One strobed cycle, bus timeout if unanswered
   // ***************************************
   task automatic access(
      input  logic [15:0] a,
      input  logic [5:0]  mod,
      input  logic        wr,
      input  logic [1:0]  ds,
      input  logic [7:0]  wd,
      output logic        ack,
      output logic [15:0] rd);
      int n;
      busOut.addr   <= a[15:1];
      busOut.am     <= mod;
      busOut.writeN <= !wr;
      busOut.data   <= wr ? wd : ~busOut.data;
      busOut.asN    <= 1'b0;
      @(posedge ref_clk);
      {busOut.ds1N, busOut.ds0N} <= ds;
      ack = 1'b0;
      n   = 0;
      while (!ack && n < WAIT_LIMIT) begin
         @(posedge ref_clk);
         n++;
         ack = localDtackOe || !busOut.dmaDtackN;
      end
      rd = {dataHiOe ? dataHi : 8'h5a, dataLoOe ? dataLo : 8'h5a};
      {busOut.asN, busOut.ds1N, busOut.ds0N} <= 3'b111;
      busOut.addr <= ~a[15:1];
      busOut.data <= ~busOut.data;
      repeat (RECOVER) @(posedge ref_clk);
   endtask : access
endmodule : vme_master_model

// ===== vme_slave_decode_config.sv
`timescale 1ns/10ps
module vme_slave_decode_config #(
   parameter int ACCESS_CYCLES = vme_decode_pkg::ACCESS_CYC
) (
   input  wire logic                    ref_clk,
   input  wire logic                    srst,
   input  wire vme_decode_pkg::vme_in_t vmeIn,
   output logic [8:1]                   heldAddr,
   output logic                         boardSelectN,
   output logic                         dmaCtrlSelectN,
   output logic                         talkerListenerSelectN,
   output logic [2:0]                   chipRegisterSelect,
   output logic                         chipRdN,
   output logic                         chipWrN,
   output logic                         localDtackOe,
   output logic                         dataLoOe,
   output logic                         dataHiOe,
   output logic [7:0]                   dataLo,
   output logic [7:0]                   dataHi,
   output logic                         clk8,
   output logic                         onboardReset,
   output logic                         dmaErrorInputN,
   output logic [2:0]                   irqPriority,
   output logic [1:0]                   busReqLevel,
   output logic                         carryCycleEnable,
   output logic                         releaseOnRequestN,
   output logic                         dmaDirection,
   output logic                         syncDetectClr,
   output logic                         localMasterReset,
   output logic                         systemController,
   output logic                         supervisorOnly,
   output logic                         sysfailOe,
   output logic                         ledRed,
   output logic                         ledGreen
);

   // ***************************************
   // State
   // ***************************************
   typedef struct packed {
      vme_decode_pkg::vme_in_t sync1;
      vme_decode_pkg::vme_in_t sync2;
      logic                    sysclkPrev;
      logic                    clk8;
      logic [8:1]              heldAddr;
      logic                    cycleOpen;
      logic                    boardSel;
      vme_decode_pkg::phase_t  phase;
      logic [4:0]              cnt;
      logic                    isRead;
      logic [7:0]              config_register_one;
      logic                    cfg1Wr;
      logic                    local_master_reset;
      logic                    sc;
      logic                    sup;
      logic                    sysfail_control;
      logic                    loOe;
      logic                    hiOe;
      logic [7:0]              loData;
      logic [7:0]              hiData;
   } state_t;

   state_t s_q;
   state_t s_d;

   logic                    decodeRst;
   logic                    obRst;
   logic                    match;
   logic                    strobesOff;
   logic                    dtackBusy;
   logic                    dmaSel;
   logic                    tlcSel;
   logic                    cfgSel;
   logic                    cfgLoad;
   logic [4:0]              lastCnt;
   vme_decode_pkg::vme_in_t b;

   localparam int ACK_DELAY = ACCESS_CYCLES;

   if (ACCESS_CYCLES < 1 || ACCESS_CYCLES > 31) begin : g_bad_cycles
      $error("ACCESS_CYCLES out of range");
   end

   assign lastCnt = 5'(ACCESS_CYCLES - 1);
   assign b       = s_q.sync2;

   // ***************************************
   // Decode
   // ***************************************
   always_comb begin
      decodeRst  = srst | ~b.sysresetN;
      obRst      = decodeRst | s_q.local_master_reset;
      match      = ~b.asN & b.iackN & b.addr[15:9] == b.baseJumper
                   & (b.am == vme_decode_pkg::AM_SIO_USER
                      | b.am == vme_decode_pkg::AM_SIO_SUP);
      strobesOff = b.asN & b.ds0N & b.ds1N;
      dtackBusy  = s_q.phase == vme_decode_pkg::PH_ACK | ~b.dmaDtackN;
      dmaSel     = s_q.boardSel & ~s_q.heldAddr[8];
      tlcSel     = s_q.boardSel & s_q.heldAddr[8] & s_q.heldAddr[4]
                   & ~b.ds0N;
      cfgSel     = s_q.boardSel & s_q.heldAddr[8] & ~s_q.heldAddr[4]
                   & ~b.ds0N;
      cfgLoad    = s_q.phase == vme_decode_pkg::PH_ACCESS
                   & s_q.cnt == lastCnt & ~s_q.isRead & cfgSel;
   end

   // ***************************************
   // Next state
   // ***************************************
   always_comb begin
      s_d        = s_q;
      s_d.sync1  = vmeIn;
      s_d.sync2  = s_q.sync1;
      s_d.cfg1Wr = 1'b0;

      s_d.sysclkPrev = b.sysclk;
      if (b.sysclk & ~s_q.sysclkPrev) begin
         s_d.clk8 = ~s_q.clk8;
      end

      if (~b.asN & ~dtackBusy & ~s_q.cycleOpen) begin
         s_d.heldAddr  = b.addr[8:1];
         s_d.cycleOpen = 1'b1;
      end
      if (match & s_q.cycleOpen & (~b.ds0N | ~b.ds1N)) begin
         s_d.boardSel = 1'b1;
      end
      if (strobesOff & ~dtackBusy) begin
         s_d.boardSel  = 1'b0;
         s_d.cycleOpen = 1'b0;
      end

      case (s_q.phase)
         vme_decode_pkg::PH_IDLE: begin
            if (tlcSel | cfgSel) begin
               s_d.phase  = vme_decode_pkg::PH_ACCESS;
               s_d.cnt    = 5'h00;
               s_d.isRead = ~b.writeN & ~b.carryByteForce ? 1'b0
                            : b.writeN & ~b.carryByteForce;
               if (b.writeN & ~b.carryByteForce) begin
                  s_d.hiOe   = 1'b1;
                  s_d.hiData = vme_decode_pkg::ALL_ONES;
                  s_d.loOe   = cfgSel;
                  s_d.loData = vme_decode_pkg::ALL_ONES;
               end
            end
         end
         vme_decode_pkg::PH_ACCESS: begin
            s_d.cnt = s_q.cnt + 5'h01;
            if (s_q.cnt == lastCnt) begin
               s_d.phase = vme_decode_pkg::PH_ACK;
            end
         end
         vme_decode_pkg::PH_ACK: begin
            if (b.ds0N & b.ds1N) begin
               s_d.phase = vme_decode_pkg::PH_RECOVER;
               s_d.cnt   = 5'h00;
               s_d.loOe  = 1'b0;
               s_d.hiOe  = 1'b0;
            end
         end
         vme_decode_pkg::PH_RECOVER: begin
            s_d.cnt = s_q.cnt + 5'h01;
            if (s_q.cnt == lastCnt) begin
               s_d.phase = vme_decode_pkg::PH_IDLE;
            end
         end
         default: begin
            s_d.phase = vme_decode_pkg::PH_IDLE;
         end
      endcase

      if (cfgLoad & ~s_q.heldAddr[2]) begin
         s_d.config_register_one   = b.data;
         s_d.cfg1Wr = 1'b1;
      end
      if (cfgLoad & s_q.heldAddr[2]) begin
         s_d.local_master_reset = b.data[vme_decode_pkg::CONFIG_REGISTER_TWO_LMR_BIT];
         s_d.sc  = b.data[vme_decode_pkg::CONFIG_REGISTER_TWO_SC_BIT];
         s_d.sup = b.data[vme_decode_pkg::CONFIG_REGISTER_TWO_SUP_BIT];
         s_d.sysfail_control = b.data[vme_decode_pkg::CONFIG_REGISTER_TWO_SFL_BIT];
      end

      if (obRst & ~cfgLoad) begin
         s_d.config_register_one = vme_decode_pkg::CONFIG_REGISTER_ONE_RST;
         s_d.sc   = 1'b0;
         s_d.sup  = b.supJumper;
      end
      if (decodeRst) begin
         s_d.local_master_reset       = 1'b0;
         s_d.sysfail_control       = 1'b0;
         s_d.config_register_one      = vme_decode_pkg::CONFIG_REGISTER_ONE_RST;
         s_d.cfg1Wr    = 1'b0;
         s_d.sc        = 1'b0;
         s_d.sup       = b.supJumper;
         s_d.boardSel  = 1'b0;
         s_d.cycleOpen = 1'b0;
         s_d.heldAddr  = 8'h00;
         s_d.phase     = vme_decode_pkg::PH_IDLE;
         s_d.cnt       = 5'h00;
         s_d.isRead    = 1'b0;
         s_d.loOe      = 1'b0;
         s_d.hiOe      = 1'b0;
         s_d.loData    = 8'h00;
         s_d.hiData    = 8'h00;
      end
      if (srst) begin
         s_d.clk8       = 1'b0;
         s_d.sysclkPrev = 1'b0;
      end
   end

   always_ff @(posedge ref_clk) begin
      s_q <= s_d;
   end

   // ***************************************
   // Outputs
   // ***************************************
   assign heldAddr              = s_q.heldAddr;
   assign boardSelectN          = ~s_q.boardSel;
   assign dmaCtrlSelectN        = ~dmaSel;
   assign talkerListenerSelectN = ~tlcSel;
   assign chipRegisterSelect    = b.carryByteForce
                                  ? vme_decode_pkg::AUX_MODE_RS
                                  : s_q.heldAddr[3:1];
   assign chipRdN  = ~(tlcSel & s_q.isRead
                      & (s_q.phase == vme_decode_pkg::PH_ACCESS
                         | s_q.phase == vme_decode_pkg::PH_ACK));
   assign chipWrN  = ~(tlcSel & ~s_q.isRead
                      & s_q.phase == vme_decode_pkg::PH_ACCESS);
   assign localDtackOe      = s_q.phase == vme_decode_pkg::PH_ACK;
   assign dataLoOe          = s_q.loOe;
   assign dataHiOe          = s_q.hiOe;
   assign dataLo            = s_q.loData;
   assign dataHi            = s_q.hiData;
   assign clk8              = s_q.clk8;
   assign onboardReset      = obRst;
   assign dmaErrorInputN    = ~(~b.berrN & ~b.ownN);
   assign irqPriority       =
      s_q.config_register_one[vme_decode_pkg::CONFIG_REGISTER_ONE_PRI_LSB +: 3];
   assign busReqLevel       =
      s_q.config_register_one[vme_decode_pkg::CONFIG_REGISTER_ONE_BR_LSB +: 2];
   assign carryCycleEnable  = s_q.config_register_one[vme_decode_pkg::CONFIG_REGISTER_ONE_CC_BIT];
   assign releaseOnRequestN = s_q.config_register_one[vme_decode_pkg::CONFIG_REGISTER_ONE_ROR_BIT];
   assign dmaDirection      = s_q.config_register_one[vme_decode_pkg::CONFIG_REGISTER_ONE_DIR_BIT];
   assign syncDetectClr     = s_q.cfg1Wr;
   assign localMasterReset  = s_q.local_master_reset;
   assign systemController  = s_q.sc;
   assign supervisorOnly    = s_q.sup;
   assign sysfailOe         = ~s_q.sysfail_control;
   assign ledRed            = ~s_q.sysfail_control;
   assign ledGreen          = s_q.sysfail_control;

   // ***************************************
   // Checks
   // ***************************************
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (srst);

   chk_sel_match: assert property ($rose(s_q.boardSel) |-> $past(match))
      else $error("board select without match");
   chk_addr_held: assert property (
      s_q.cycleOpen && $past(s_q.cycleOpen) && !$past(decodeRst)
      |-> $stable(s_q.heldAddr))
      else $error("held address changed mid cycle");
   chk_sel_excl: assert property (!dmaCtrlSelectN |-> talkerListenerSelectN
      && !cfgSel)
      else $error("two selects at once");
   chk_cfg_ones: assert property (localDtackOe && s_q.isRead && cfgSel
      |-> dataLoOe && dataLo == 8'hff && dataHi == 8'hff)
      else $error("config read not all ones");
   chk_ack_delay: assert property (
      $rose(s_q.phase == vme_decode_pkg::PH_ACCESS) && !decodeRst
      |-> ##ACK_DELAY (localDtackOe || $past(decodeRst)))
      else $error("acknowledge timing wrong");
   chk_bsel_hold: assert property (s_q.boardSel && !strobesOff
      && !decodeRst |=> s_q.boardSel)
      else $error("board select dropped early");
   chk_no_resp: assert property (
      s_q.phase == vme_decode_pkg::PH_IDLE && !tlcSel && !cfgSel
      |=> !localDtackOe)
      else $error("answer to unmapped access");
   chk_clk_div: assert property (b.sysclk && !s_q.sysclkPrev
      |=> clk8 != $past(clk8))
      else $error("divided clock did not toggle");
   chk_lmr_write: assert property (cfgLoad && s_q.heldAddr[2]
      && b.data[0] && !decodeRst |=> localMasterReset ##0 onboardReset)
      else $error("master reset bit not loaded");
   chk_config_register_one_rst: assert property (obRst && !cfgLoad
      |=> s_q.config_register_one == 8'h02)
      else $error("register one reset value wrong");
   chk_sfl_rst: assert property (decodeRst |=> sysfailOe && ledRed)
      else $error("sysfail not driven after reset");
   chk_sync_pulse: assert property (cfgLoad && !s_q.heldAddr[2]
      && !decodeRst |=> syncDetectClr)
      else $error("sync detector clear missing");
   chk_bsel_free: assert property (s_q.boardSel && strobesOff
      && !dtackBusy |=> boardSelectN)
      else $error("board select not released");
   chk_tlc_lane: assert property (!talkerListenerSelectN |-> !dataLoOe)
      else $error("low lane driven for chip");
   chk_dma_quiet: assert property (!dmaCtrlSelectN
      |-> !localDtackOe && !dataLoOe && !dataHiOe)
      else $error("local answer to DMA controller access");
   chk_lmr_keep: assert property (localMasterReset && !decodeRst
      && !cfgLoad |=> localMasterReset)
      else $error("master reset bit lost");

   cov_tlc_read: cover property (tlcSel && s_q.isRead && localDtackOe);
   cov_config_register_one_write: cover property (s_q.cfg1Wr);
   cov_dma_sel: cover property (!dmaCtrlSelectN);
   cov_lmr: cover property ($rose(localMasterReset));
   cov_dma_err: cover property (!dmaErrorInputN);

endmodule : vme_slave_decode_config

// ===== vme_slave_decode_config_bench.sv
`timescale 1ns/10ps
// ***************************************
// Bench for the short I/O decoder
// ***************************************
module vme_slave_decode_config_bench;
   typedef struct packed {
      logic [15:0] addr;
      logic [5:0]  am;
      logic        wr;
      logic [1:0]  ds;
      logic [7:0]  wd;
      logic        ack;
      logic [15:0] rd;
      logic [15:0] mask;
      logic [2:0]  sel;
      logic [7:0]  cfg;
   } row_t;

   localparam row_t ROWS [13] = '{
      '{16'h2b00,6'h29,1'b1,2'b10,8'hb5,1'b1,16'h0,16'h0,3'h4,8'hb5},
      '{16'h2b00,6'h2d,1'b0,2'b00,8'h00,1'b1,16'hffff,16'hffff,3'h4,8'hb5},
      '{16'h2b04,6'h29,1'b1,2'b00,8'h0a,1'b1,16'h0,16'h0,3'h4,8'hb5},
      '{16'h2b04,6'h2d,1'b0,2'b10,8'h00,1'b1,16'h00ff,16'h00ff,3'h4,8'hb5},
      '{16'h2b00,6'h2d,1'b1,2'b00,8'h5c,1'b1,16'h0,16'h0,3'h4,8'h5c},
      '{16'h2b10,6'h29,1'b1,2'b10,8'h33,1'b1,16'h0,16'h0,3'h5,8'h5c},
      '{16'h2b1e,6'h29,1'b0,2'b00,8'h00,1'b1,16'hff00,16'hff00,3'h5,8'h5c},
      '{16'h2a20,6'h29,1'b0,2'b00,8'h00,1'b1,16'h0,16'h0,3'h6,8'h5c},
      '{16'h2afe,6'h2d,1'b1,2'b01,8'h11,1'b1,16'h0,16'h0,3'h6,8'h5c},
      '{16'h2b10,6'h29,1'b1,2'b01,8'h22,1'b0,16'h0,16'h0,3'h4,8'h5c},
      '{16'h2b00,6'h39,1'b1,2'b10,8'h99,1'b0,16'h0,16'h0,3'h0,8'h5c},
      '{16'h2c00,6'h29,1'b1,2'b10,8'h99,1'b0,16'h0,16'h0,3'h0,8'h5c},
      '{16'h2b00,6'h29,1'b1,2'b10,8'h47,1'b1,16'h0,16'h0,3'h4,8'h47}};

   logic ref_clk, srst, berrN, sysresetN, sysclk, ownN;
   logic carryByteForce, supJumper, ack, sPrev, cPrev;
   logic chipRdN, chipWrN, systemController;
   logic boardSelectN, dmaCtrlSelectN, talkerListenerSelectN, localDtackOe;
   logic dataLoOe, dataHiOe, clk8, onboardReset, dmaErrorInputN;
   logic carryCycleEnable, releaseOnRequestN, dmaDirection, syncDetectClr;
   logic localMasterReset, supervisorOnly, sysfailOe, ledRed, ledGreen;
   logic [8:1]  heldAddr;
   logic [7:0]  dataLo, dataHi;
   logic [2:0]  chipRegisterSelect, irqPriority, selSeen, rsSeen;
   logic [1:0]  busReqLevel, strbSeen;
   logic [15:0] rd;
   int          errors, nCompared, nSync, sRise, cRise, sDiv;
   vme_decode_pkg::vme_in_t busOut, vmeIn;
   wire logic [7:0] cfgView = {irqPriority, busReqLevel, carryCycleEnable,
                               releaseOnRequestN, dmaDirection};

   vme_slave_decode_config vme_slave_decode_config_inst (
      .ref_clk(ref_clk), .srst(srst), .vmeIn(vmeIn), .heldAddr(heldAddr),
      .boardSelectN(boardSelectN), .dmaCtrlSelectN(dmaCtrlSelectN),
      .talkerListenerSelectN(talkerListenerSelectN),
      .chipRegisterSelect(chipRegisterSelect), .chipRdN(chipRdN),
      .chipWrN(chipWrN),
      .localDtackOe(localDtackOe), .dataLoOe(dataLoOe), .dataHiOe(dataHiOe),
      .dataLo(dataLo), .dataHi(dataHi), .clk8(clk8),
      .onboardReset(onboardReset), .dmaErrorInputN(dmaErrorInputN),
      .irqPriority(irqPriority), .busReqLevel(busReqLevel),
      .carryCycleEnable(carryCycleEnable),
      .releaseOnRequestN(releaseOnRequestN), .dmaDirection(dmaDirection),
      .syncDetectClr(syncDetectClr), .localMasterReset(localMasterReset),
      .systemController(systemController), .supervisorOnly(supervisorOnly),
      .sysfailOe(sysfailOe), .ledRed(ledRed), .ledGreen(ledGreen));

   vme_master_model vme_master_model_inst (
      .ref_clk(ref_clk), .localDtackOe(localDtackOe),
      .dmaCtrlSelectN(dmaCtrlSelectN), .dataLoOe(dataLoOe),
      .dataHiOe(dataHiOe), .dataLo(dataLo), .dataHi(dataHi),
      .busOut(busOut));

   // ***************************************
   // Wire levels, clocks and monitors
   // ***************************************
   always_comb begin
      vmeIn                = busOut;
      vmeIn.data           = dataLoOe ? dataLo : busOut.data;
      vmeIn.berrN          = berrN;
      vmeIn.sysresetN      = sysresetN;
      vmeIn.sysclk         = sysclk;
      vmeIn.ownN           = ownN;
      vmeIn.carryByteForce = carryByteForce;
      vmeIn.supJumper      = supJumper;
      vmeIn.baseJumper     = 7'h15;
   end

   always #(vme_decode_pkg::CLK_PERIOD_NS / 2) ref_clk = ~ref_clk;

   always @(posedge ref_clk) begin
      sDiv <= (sDiv == 2) ? 0 : sDiv + 1;
      if (sDiv == 2) sysclk <= ~sysclk;
      sPrev <= sysclk;
      cPrev <= clk8;
      if (sysclk && !sPrev) sRise <= sRise + 1;
      if (clk8 && !cPrev) cRise <= cRise + 1;
      if (syncDetectClr) nSync <= nSync + 1;
      if (!boardSelectN) selSeen[2] <= 1'b1;
      if (!dmaCtrlSelectN) selSeen[1] <= 1'b1;
      if (!talkerListenerSelectN) selSeen[0] <= 1'b1;
      if (!talkerListenerSelectN) rsSeen <= chipRegisterSelect;
      if (!chipRdN) strbSeen[1] <= 1'b1;
      if (!chipWrN) strbSeen[0] <= 1'b1;
   end

   task chk(input logic [15:0] got, input logic [15:0] exp);
      nCompared++;
      if (got !== exp) begin
         $display("Error at %0t: got %h expected %h", $time, got, exp);
         errors++;
      end
   endtask : chk

   task print_verdict;
      if (errors == 0 && nCompared > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : print_verdict

   task cyc(input logic [15:0] a, input logic wr, input logic [7:0] wd);
      vme_master_model_inst.access(a, 6'h29, wr, 2'b10, wd, ack, rd);
   endtask : cyc

   initial begin
      repeat (10000) @(posedge ref_clk);
      errors++;
      print_verdict();
   end

   // ***************************************
   // Main sequence
   // ***************************************
   initial begin
      {ref_clk, sysclk, carryByteForce, sPrev, cPrev} = '0;
      {srst, berrN, sysresetN, ownN, supJumper} = '1;
      {errors, nCompared, nSync, sRise, cRise, sDiv} = '0;
      {selSeen, rsSeen, strbSeen} = '0;
      repeat (8) @(posedge ref_clk);
      srst <= 1'b0;
      repeat (4) @(posedge ref_clk);
      chk(cfgView, 8'h02);
      chk({ledRed, sysfailOe, boardSelectN, localMasterReset}, 4'he);
      for (int i = 0; i < 13; i++) begin
         selSeen <= 3'h0;
         strbSeen <= 2'b00;
         @(posedge ref_clk);
         vme_master_model_inst.access(ROWS[i].addr, ROWS[i].am, ROWS[i].wr,
                                      ROWS[i].ds, ROWS[i].wd, ack, rd);
         chk(ack, ROWS[i].ack);
         chk(rd & ROWS[i].mask, ROWS[i].rd);
         chk(selSeen, ROWS[i].sel);
         chk(cfgView, ROWS[i].cfg);
         chk(heldAddr, ROWS[i].addr[8:1]);
         chk(boardSelectN, 1'b1);
         if (ROWS[i].sel[0]) chk(rsSeen, ROWS[i].addr[3:1]);
         chk(strbSeen, ROWS[i].sel[0] ? {!ROWS[i].wr, ROWS[i].wr}
                                      : 2'b00);
      end
      chk(nSync, 3);
      chk({systemController, supervisorOnly}, 2'b10);
      cyc(16'h2b04, 1'b1, 8'h09);
      chk({ack, onboardReset, ledGreen, cfgView}, {3'h7, 8'h02});
      chk({systemController, supervisorOnly}, 2'b01);
      cyc(16'h2b04, 1'b1, 8'h08);
      chk({ack, onboardReset, ledGreen, localMasterReset}, 4'ha);
      carryByteForce <= 1'b1;
      strbSeen <= 2'b00;
      @(posedge ref_clk);
      cyc(16'h2b1c, 1'b0, 8'h00);
      chk({ack, rsSeen, rd[7:0]}, {1'b1, 3'h3, 8'h5a});
      chk(strbSeen, 2'b01);
      carryByteForce <= 1'b0;
      ownN <= 1'b0;
      berrN <= 1'b0;
      repeat (4) @(posedge ref_clk);
      chk(dmaErrorInputN, 1'b0);
      ownN <= 1'b1;
      repeat (4) @(posedge ref_clk);
      chk(dmaErrorInputN, 1'b1);
      berrN <= 1'b1;
      sysresetN <= 1'b0;
      repeat (4) @(posedge ref_clk);
      chk(onboardReset, 1'b1);
      sysresetN <= 1'b1;
      repeat (4) @(posedge ref_clk);
      chk({onboardReset, ledRed, sysfailOe, localMasterReset}, 4'h6);
      chk((sRise > 2 * cRise + 2) || (2 * cRise > sRise + 2), 1'b0);
      chk(sRise > 50, 1'b1);
      print_verdict();
   end
endmodule : vme_slave_decode_config_bench
